// ===== design/dlts_pkg.sv
// constants and types for the loopback test supervisor
package dlts_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERRCNT = 8'h08;
  localparam int CTRL_LOOP_BIT = 0;
  localparam int CTRL_PAT_BIT = 1;
  localparam int CTRL_INJ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // ==========================================
  // timing; clock in Hz, durations in milliseconds
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int RESTART_DATA_MS = 4 * MS_PER_S;
  localparam int RESTART_START_MS = 50 * MS_PER_S;
  localparam int RESTART_PAT_MS = 60 * MS_PER_S;
  localparam int RESTART_FAR_MS = 60 * MS_PER_S;
  localparam int PAT_TIMEOUT_MS = 45 * MS_PER_S;
  localparam int BLINK_MS = 200;
  localparam int TEST_FLASH_MS = 400;
  localparam int ERR_FLASH_MS = 50;
  localparam int MS_W = 16;
  // ==========================================
  // pattern generator, 9-stage sequence
  localparam int PRBS_W = 9;
  localparam int PRBS_TAP = 4;
  localparam logic [8:0] PRBS_SEED = 9'h1FF;
  localparam int ERRCNT_W = 16;
  // ==========================================
  // link states
  typedef enum logic [1:0] {
    ST_STARTUP,
    ST_DATA,
    ST_LOOP1,
    ST_LOOP2
  } dlts_state_e;
endpackage : dlts_pkg

// ===== design/dlts_supervisor.sv
// link supervisor: indicators, restart timer, pattern test, loops
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dlts_supervisor
  import dlts_pkg::*;
#(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SW_LOOP,
  input wire logic SW_PATTERN,
  input wire logic DTE_LOOP_REQ,
  input wire logic DTE_PATTERN_REQ,
  input wire logic RATE_UNSUPPORTED,
  input wire logic DTE_TXD,
  input wire logic LINE_RXD,
  input wire logic BIT_EN,
  input wire logic FRAMER_LINE_TXD,
  input wire logic FRAMER_DTE_RXD,
  input wire logic RX_FRAMED,
  input wire logic RX_FRAME_STROBE,
  input wire logic RX_CRC_ERR,
  input wire logic MGMT_PKT_VALID,
  input wire logic FAR_END_LOOPBACK,
  output logic LINE_TXD,
  output logic DTE_RXD,
  output logic FRAMER_LINE_RXD,
  output logic FRAMER_LOOP,
  output logic LINK_RESTART,
  output logic CTS,
  output logic CD,
  output logic SPAN_UP_INDICATOR,
  output logic NO_LINK_INDICATOR,
  output logic ERROR_INDICATOR,
  output logic TEST_ACTIVE_INDICATOR,
  output logic TXD_YELLOW,
  output logic TXD_GREEN,
  output logic RXD_YELLOW,
  output logic RXD_GREEN
);

  // ==========================================
  // pin synchronisers
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {SW_LOOP, SW_PATTERN, DTE_LOOP_REQ, DTE_PATTERN_REQ,
                    RATE_UNSUPPORTED, DTE_TXD, LINE_RXD};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // no reset: the strap must already be through both stages at release
      always_ff @(posedge CLK) begin
        sync1_reg[gi] <= pin_raw[gi];
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  endgenerate
  logic sw_loop, sw_pat, dte_loop, dte_pat, rate_bad_pin, dte_txd, line_rxd;
  assign {sw_loop, sw_pat, dte_loop, dte_pat, rate_bad_pin, dte_txd,
          line_rxd} = sync2_reg;

  // ==========================================
  // apb slave, zero wait states
  logic [2:0] ctrl_reg;
  logic [ERRCNT_W-1:0] errcnt_reg;
  logic apb_wr, addr_ok;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                   (PADDR == ADDR_ERRCNT);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && PADDR == ADDR_CTRL) begin
      ctrl_reg <= PWDATA[2:0];
    end
  end

  // ==========================================
  // requests: switch, terminal line and register are equivalent
  logic loop_req, pat_req;
  assign loop_req = sw_loop | dte_loop | ctrl_reg[CTRL_LOOP_BIT];
  assign pat_req = sw_pat | dte_pat | ctrl_reg[CTRL_PAT_BIT];

  // ==========================================
  // millisecond tick
  logic [31:0] pre_reg;
  logic ms_tick;
  assign ms_tick = (pre_reg == 32'(MS_CYCLES - 1));
  always_ff @(posedge CLK) begin
    if (RESET || ms_tick) begin
      pre_reg <= 32'h0;
    end else begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  // ==========================================
  // link state and restart timer
  dlts_state_e state_reg;
  logic [MS_W-1:0] unf_reg;
  logic [MS_W-1:0] limit;
  logic restart, linked, pat_on;
  assign linked = (state_reg == ST_DATA) || (state_reg == ST_LOOP2);
  always_comb begin
    if (pat_on) begin
      limit = MS_W'(RESTART_PAT_MS);
    end else if (FAR_END_LOOPBACK) begin
      limit = MS_W'(RESTART_FAR_MS);
    end else if (state_reg == ST_STARTUP) begin
      limit = MS_W'(RESTART_START_MS);
    end else begin
      limit = MS_W'(RESTART_DATA_MS);
    end
  end
  // any unframed stretch counts, whatever the reason for it, except in loop mode 1, where no restart is raised
  assign restart = ms_tick && (unf_reg >= limit - MS_W'(1)) &&
                   state_reg != ST_LOOP1;
  always_ff @(posedge CLK) begin
    if (RESET || restart || RX_FRAME_STROBE || RX_FRAMED) begin
      unf_reg <= '0;
    end else if (state_reg == ST_LOOP1 && !pat_on) begin
      unf_reg <= '0;
    end else if (ms_tick) begin
      unf_reg <= unf_reg + MS_W'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LINK_RESTART <= 1'b0;
    end else begin
      LINK_RESTART <= restart;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= ST_STARTUP;
    end else begin
      case (state_reg)
        ST_STARTUP: begin
          if (loop_req) begin
            state_reg <= ST_LOOP1;
          end else if (RX_FRAMED) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (restart) begin
            state_reg <= ST_STARTUP;
          end else if (loop_req) begin
            state_reg <= ST_LOOP2;
          end
        end
        ST_LOOP1: begin
          if (!loop_req) begin
            state_reg <= ST_STARTUP;
          end
        end
        ST_LOOP2: begin
          if (restart) begin
            state_reg <= ST_STARTUP;
          end else if (!loop_req) begin
            state_reg <= ST_DATA;
          end
        end
        default: state_reg <= ST_STARTUP;
      endcase
    end
  end

  // ==========================================
  // pattern generator with 45 s limit
  logic [MS_W-1:0] pat_ms_reg;
  logic timed_out_reg;
  logic [PRBS_W-1:0] gen_reg;
  logic [PRBS_W-1:0] chk_reg;
  logic gen_bit, det_in, det_err;
  // mode 2 leaves the local generator with no path
  assign pat_on = pat_req && !timed_out_reg && state_reg != ST_LOOP2;
  always_ff @(posedge CLK) begin
    if (RESET || !pat_on) begin
      pat_ms_reg <= '0;
    end else if (ms_tick) begin
      pat_ms_reg <= pat_ms_reg + MS_W'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET || !pat_req) begin
      timed_out_reg <= 1'b0;
    end else if (pat_on && ms_tick &&
                 pat_ms_reg == MS_W'(PAT_TIMEOUT_MS - 1)) begin
      timed_out_reg <= 1'b1;
    end
  end
  // 511E variant flips every generated bit into an error
  assign gen_bit = gen_reg[PRBS_W-1] ^ ctrl_reg[CTRL_INJ_BIT];
  always_ff @(posedge CLK) begin
    if (RESET || !pat_on) begin
      gen_reg <= PRBS_SEED;
    end else if (BIT_EN) begin
      gen_reg <= {gen_reg[PRBS_W-2:0],
                  gen_reg[PRBS_W-1] ^ gen_reg[PRBS_TAP]};
    end
  end
  // self-synchronising checker, fed locally in mode 1
  assign det_in = (state_reg == ST_LOOP1) ? gen_bit : line_rxd;
  assign det_err = pat_on && BIT_EN &&
                   (det_in != (chk_reg[PRBS_W-1] ^ chk_reg[PRBS_TAP]));
  always_ff @(posedge CLK) begin
    if (RESET) begin
      chk_reg <= '0;
    end else if (BIT_EN) begin
      chk_reg <= {chk_reg[PRBS_W-2:0], det_in};
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET || (pat_req && !pat_on && !timed_out_reg)) begin
      errcnt_reg <= '0;
    end else if (det_err && errcnt_reg != '1) begin
      errcnt_reg <= errcnt_reg + ERRCNT_W'(1);
    end
  end

  // ==========================================
  // data paths, registered on bit strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LINE_TXD <= 1'b1;
      DTE_RXD <= 1'b1;
      FRAMER_LINE_RXD <= 1'b1;
      FRAMER_LOOP <= 1'b0;
    end else begin
      FRAMER_LOOP <= (state_reg == ST_LOOP2);
      if (BIT_EN) begin
        FRAMER_LINE_RXD <= line_rxd;
        if (state_reg == ST_LOOP1) begin
          LINE_TXD <= 1'b1;
          DTE_RXD <= dte_txd;
        end else begin
          if (state_reg == ST_LOOP2 || FAR_END_LOOPBACK) begin
            LINE_TXD <= line_rxd;
          end else if (pat_on) begin
            LINE_TXD <= gen_bit;
          end else begin
            LINE_TXD <= FRAMER_LINE_TXD;
          end
          DTE_RXD <= FRAMER_DTE_RXD;
        end
      end
    end
  end

  // ==========================================
  // indicators and modem controls
  logic rate_bad_reg, armed_reg, blink_reg;
  logic [MS_W-1:0] blink_ms_reg;
  logic [MS_W-1:0] err_ms_reg;
  logic [MS_W-1:0] tst_ms_reg;
  // strap caught once, on the first cycle after release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      armed_reg <= 1'b1;
      rate_bad_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b0;
      if (armed_reg) begin
        rate_bad_reg <= rate_bad_pin;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      blink_ms_reg <= '0;
      blink_reg <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms_reg == MS_W'(BLINK_MS / 2 - 1)) begin
        blink_ms_reg <= '0;
        blink_reg <= !blink_reg;
      end else begin
        blink_ms_reg <= blink_ms_reg + MS_W'(1);
      end
    end
  end
  // a new error restarts the stretch; bursts merge into one flash
  always_ff @(posedge CLK) begin
    if (RESET) begin
      err_ms_reg <= '0;
    end else if ((RX_CRC_ERR && !pat_on) || det_err) begin
      err_ms_reg <= MS_W'(ERR_FLASH_MS);
    end else if (ms_tick && err_ms_reg != '0) begin
      err_ms_reg <= err_ms_reg - MS_W'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tst_ms_reg <= '0;
    end else if (MGMT_PKT_VALID) begin
      tst_ms_reg <= MS_W'(TEST_FLASH_MS);
    end else if (ms_tick && tst_ms_reg != '0) begin
      tst_ms_reg <= tst_ms_reg - MS_W'(1);
    end
  end
  logic test_mode;
  assign test_mode = pat_on || timed_out_reg || FAR_END_LOOPBACK ||
                     state_reg == ST_LOOP1 || state_reg == ST_LOOP2;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SPAN_UP_INDICATOR <= 1'b0;
      NO_LINK_INDICATOR <= 1'b1;
      CTS <= 1'b0;
      CD <= 1'b0;
      ERROR_INDICATOR <= 1'b0;
      TEST_ACTIVE_INDICATOR <= 1'b0;
      TXD_YELLOW <= 1'b0;
      TXD_GREEN <= 1'b0;
      RXD_YELLOW <= 1'b0;
      RXD_GREEN <= 1'b0;
    end else begin
      SPAN_UP_INDICATOR <= linked;
      NO_LINK_INDICATOR <= !linked;
      CTS <= RX_FRAMED;
      CD <= RX_FRAMED;
      ERROR_INDICATOR <= (err_ms_reg != '0) ||
                         (rate_bad_reg && blink_reg) ||
                         (timed_out_reg && blink_reg);
      TEST_ACTIVE_INDICATOR <= test_mode || (tst_ms_reg != '0);
      TXD_YELLOW <= dte_txd;
      TXD_GREEN <= !dte_txd;
      RXD_YELLOW <= DTE_RXD;
      RXD_GREEN <= !DTE_RXD;
    end
  end

  // ==========================================
  // register reads
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL: PRDATA <= {29'h0, ctrl_reg};
        ADDR_STATUS: PRDATA <= {25'h0, rate_bad_reg, FAR_END_LOOPBACK,
                                timed_out_reg, pat_on, linked, state_reg};
        ADDR_ERRCNT: PRDATA <= {16'h0, errcnt_reg};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_loop_start;
    loop_req && !$past(loop_req);
  endsequence
  chk_span_follows: assert property (##1 SPAN_UP_INDICATOR == $past(linked))
    else $error("span indicator wrong");
  chk_nolink_inverse: assert property (NO_LINK_INDICATOR != SPAN_UP_INDICATOR)
    else $error("no-link indicator wrong");
  chk_cts_cd_pair: assert property (##1 CTS == $past(RX_FRAMED) && CD == CTS)
    else $error("cts or cd wrong");
  chk_loop_entry: assert property (s_loop_start and state_reg == ST_STARTUP |=> state_reg == ST_LOOP1)
    else $error("loop mode 1 not entered");
  chk_loop2_entry: assert property (loop_req && state_reg == ST_DATA && !restart |=> state_reg == ST_LOOP2)
    else $error("loop mode 2 not entered");
  chk_loop2_release: assert property (state_reg == ST_LOOP2 && !loop_req && !restart |=> state_reg == ST_DATA)
    else $error("loop mode 2 not released");
  chk_frame_clears: assert property (RX_FRAME_STROBE |=> unf_reg == '0)
    else $error("restart timer not cleared");
  chk_restart_pulse: assert property (restart |=> LINK_RESTART && state_reg == ST_STARTUP)
    else $error("restart not taken");
  chk_test_led: assert property (test_mode |=> TEST_ACTIVE_INDICATOR)
    else $error("test indicator off");
  chk_mgmt_flash: assert property (MGMT_PKT_VALID |=> tst_ms_reg == MS_W'(TEST_FLASH_MS))
    else $error("test flash not started");
  chk_timeout_hold: assert property (timed_out_reg && pat_req |=> timed_out_reg && !pat_on)
    else $error("generator restarted");
  chk_err_stretch: assert property (det_err |=> err_ms_reg == MS_W'(ERR_FLASH_MS) ##1 ERROR_INDICATOR)
    else $error("error flash missing");
  chk_loop1_path: assert property (state_reg == ST_LOOP1 && BIT_EN |=> LINE_TXD && DTE_RXD == $past(dte_txd))
    else $error("mode 1 path wrong");

endmodule : dlts_supervisor

`default_nettype wire

// ===== verif/dlts_peer_model.sv
// peer line driver model as seen through the local framer
`timescale 1ns/1ps
`default_nettype none
module dlts_peer_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic framed_en,
  input wire logic crc_bad,
  output logic rx_framed,
  output logic rx_frame_strobe,
  output logic rx_crc_err,
  output logic line_rxd,
  output logic bit_en
);
  logic [3:0] cnt_reg;
  logic [8:0] noise_reg;
  // ==========================================
  // bit timing and line data
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      noise_reg <= 9'h1A5;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg[1:0] == 2'h3) begin
        noise_reg <= {noise_reg[7:0], noise_reg[8] ^ noise_reg[3]};
      end
    end
  end
  // ==========================================
  // framing: unframed line data keeps changing, never a frozen level
  assign bit_en = (cnt_reg[1:0] == 2'h3);
  assign rx_framed = framed_en;
  assign rx_frame_strobe = framed_en && (cnt_reg == 4'hF);
  assign rx_crc_err = crc_bad && framed_en;
  assign line_rxd = noise_reg[0];
endmodule : dlts_peer_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the loopback test supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dlts_pkg::*;
  localparam int MSC = 4;
  localparam int RESTART_CYC = RESTART_DATA_MS * MSC;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, seed;
  logic SW_LOOP, SW_PATTERN, DTE_LOOP_REQ, DTE_PATTERN_REQ, RATE_UNSUPPORTED;
  logic DTE_TXD, LINE_RXD, BIT_EN, FRAMER_LINE_TXD, FRAMER_DTE_RXD;
  logic RX_FRAMED, RX_FRAME_STROBE, RX_CRC_ERR, MGMT_PKT_VALID;
  logic LINE_TXD, DTE_RXD, FRAMER_LINE_RXD, FRAMER_LOOP, LINK_RESTART;
  logic CTS, CD, SPAN_UP_INDICATOR, NO_LINK_INDICATOR, ERROR_INDICATOR;
  logic TEST_ACTIVE_INDICATOR, TXD_YELLOW, TXD_GREEN, RXD_YELLOW, RXD_GREEN;
  logic framed_en, crc_bad, err, far_loop;
  int bad_count, cmp_count, n, k;

  dlts_supervisor #(.MS_CYCLES(MSC)) i_dlts_supervisor (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SW_LOOP(SW_LOOP),
    .SW_PATTERN(SW_PATTERN), .DTE_LOOP_REQ(DTE_LOOP_REQ),
    .DTE_PATTERN_REQ(DTE_PATTERN_REQ), .RATE_UNSUPPORTED(RATE_UNSUPPORTED),
    .DTE_TXD(DTE_TXD), .LINE_RXD(LINE_RXD), .BIT_EN(BIT_EN),
    .FRAMER_LINE_TXD(FRAMER_LINE_TXD), .FRAMER_DTE_RXD(FRAMER_DTE_RXD),
    .RX_FRAMED(RX_FRAMED), .RX_FRAME_STROBE(RX_FRAME_STROBE),
    .RX_CRC_ERR(RX_CRC_ERR), .MGMT_PKT_VALID(MGMT_PKT_VALID),
    .FAR_END_LOOPBACK(far_loop), .LINE_TXD(LINE_TXD), .DTE_RXD(DTE_RXD),
    .FRAMER_LINE_RXD(FRAMER_LINE_RXD), .FRAMER_LOOP(FRAMER_LOOP),
    .LINK_RESTART(LINK_RESTART), .CTS(CTS), .CD(CD),
    .SPAN_UP_INDICATOR(SPAN_UP_INDICATOR),
    .NO_LINK_INDICATOR(NO_LINK_INDICATOR), .ERROR_INDICATOR(ERROR_INDICATOR),
    .TEST_ACTIVE_INDICATOR(TEST_ACTIVE_INDICATOR), .TXD_YELLOW(TXD_YELLOW),
    .TXD_GREEN(TXD_GREEN), .RXD_YELLOW(RXD_YELLOW), .RXD_GREEN(RXD_GREEN)
  );
  dlts_peer_model i_dlts_peer_model (
    .clk(CLK), .reset(RESET), .framed_en(framed_en), .crc_bad(crc_bad),
    .rx_framed(RX_FRAMED), .rx_frame_strobe(RX_FRAME_STROBE),
    .rx_crc_err(RX_CRC_ERR), .line_rxd(LINE_RXD), .bit_en(BIT_EN)
  );

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // a full 511-bit period holds 256 ones; the inverted form one fewer
  function automatic int ones_exp(input logic inv);
    return inv ? 255 : 256;
  endfunction : ones_exp
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic cyc(input int c);
    repeat (c) @(posedge CLK);
  endtask : cyc
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      w++;
    end while (PREADY !== 1'b1 && w < 20);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (w >= 20) begin
      bad_count++;
      finish_test();
    end
  endtask : apb
  // source 0 panel switch, 1 terminal line, 2 control register
  task automatic request(input int s, input logic [2:0] ctl, input logic v);
    if (s == 2) begin
      apb(1'b1, ADDR_CTRL, {29'h0, ctl & {3{v}}});
    end else if (s == 0) begin
      SW_LOOP <= ctl[0] & v;
      SW_PATTERN <= ctl[1] & v;
    end else begin
      DTE_LOOP_REQ <= ctl[0] & v;
      DTE_PATTERN_REQ <= ctl[1] & v;
    end
  endtask : request
  task automatic wait_err(input logic v);
    n = 0;
    while (ERROR_INDICATOR !== v && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
    end
  endtask : wait_err
  task automatic count_ones(output int c);
    c = 0;
    for (int i = 0; i < 511; i++) begin
      for (n = 0; n < 8 && BIT_EN !== 1'b1; n++) begin
        @(posedge CLK);
      end
      @(posedge CLK);
      c += (LINE_TXD === 1'b1) ? 1 : 0;
    end
  endtask : count_ones
  // ==========================================
  // main sequence
  initial begin
    seed = 32'd82425;
    {PSEL, PENABLE, PWRITE, SW_LOOP, SW_PATTERN, DTE_LOOP_REQ} = '0;
    {DTE_PATTERN_REQ, DTE_TXD, FRAMER_LINE_TXD, FRAMER_DTE_RXD} = '0;
    {MGMT_PKT_VALID, framed_en, crc_bad, far_loop} = '0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    RATE_UNSUPPORTED = 1'b1;
    RESET = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    cyc(4);
    RESET <= 1'b0;
    wait_err(1'b1);
    wait_err(1'b0);
    k = n;
    wait_err(1'b1);
    check(k + n, 2 * (BLINK_MS / 2) * MSC);
    RATE_UNSUPPORTED <= 1'b0;
    RESET <= 1'b1;
    cyc(4);
    RESET <= 1'b0;
    cyc(2);
    check(NO_LINK_INDICATOR, 1'b1);
    check(SPAN_UP_INDICATOR, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    for (int s = 0; s < 3; s++) begin
      DTE_TXD <= seed[0];
      seed = lfsr_next(seed);
      request(s, 3'h1, 1'b1);
      cyc(8);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[1:0], ST_LOOP1);
      check(TEST_ACTIVE_INDICATOR, 1'b1);
      check(DTE_RXD, DTE_TXD);
      check(LINE_TXD, 1'b1);
      check(ERROR_INDICATOR, 1'b0);
      request(s, 3'h1, 1'b0);
      cyc(8);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[1:0], ST_STARTUP);
      check(TEST_ACTIVE_INDICATOR, 1'b0);
    end
    framed_en <= 1'b1;
    cyc(40);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], ST_DATA);
    check(SPAN_UP_INDICATOR, 1'b1);
    check(NO_LINK_INDICATOR, 1'b0);
    check({CTS, CD}, 2'h3);
    for (int i = 0; i < 8; i++) begin
      DTE_TXD <= seed[0];
      FRAMER_DTE_RXD <= seed[1];
      seed = lfsr_next(seed);
      cyc(12);
      check({TXD_YELLOW, TXD_GREEN}, {DTE_TXD, ~DTE_TXD});
      check({RXD_YELLOW, RXD_GREEN}, {DTE_RXD, ~DTE_RXD});
      check(DTE_RXD, FRAMER_DTE_RXD);
    end
    request(0, 3'h1, 1'b1);
    cyc(8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], ST_LOOP2);
    check(FRAMER_LOOP, 1'b1);
    request(0, 3'h1, 1'b0);
    cyc(8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], ST_DATA);
    check(FRAMER_LOOP, 1'b0);
    // far end of a remote loop: line data back to line and on to framer
    far_loop <= 1'b1;
    cyc(8);
    for (int i = 0; i < 6; i++) begin
      cyc(3);
      check(LINE_TXD, FRAMER_LINE_RXD);
      check(TEST_ACTIVE_INDICATOR, 1'b1);
    end
    far_loop <= 1'b0;
    cyc(8);
    check(TEST_ACTIVE_INDICATOR, 1'b0);
    crc_bad <= 1'b1;
    cyc(1);
    crc_bad <= 1'b0;
    cyc(8);
    check(ERROR_INDICATOR, 1'b1);
    cyc(ERR_FLASH_MS * MSC + 20);
    check(ERROR_INDICATOR, 1'b0);
    MGMT_PKT_VALID <= 1'b1;
    cyc(1);
    MGMT_PKT_VALID <= 1'b0;
    cyc(4);
    check(TEST_ACTIVE_INDICATOR, 1'b1);
    cyc(TEST_FLASH_MS * MSC - 20);
    check(TEST_ACTIVE_INDICATOR, 1'b1);
    cyc(30);
    check(TEST_ACTIVE_INDICATOR, 1'b0);
    // framer output held low so any leak past the generator shows up
    for (int s = 0; s < 3; s++) begin
      request(s, (s == 2) ? 3'h6 : 3'h2, 1'b1);
      cyc(40);
      check(TEST_ACTIVE_INDICATOR, 1'b1);
      count_ones(k);
      check(k, ones_exp(s == 2));
      request(s, 3'h6, 1'b0);
      cyc(40);
    end
    framed_en <= 1'b0;
    cyc(10);
    check({CTS, CD}, 2'h0);
    cyc(RESTART_CYC - 4000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], ST_DATA);
    framed_en <= 1'b1;
    cyc(40);
    framed_en <= 1'b0;
    n = 0;
    while (LINK_RESTART !== 1'b1 && n < RESTART_CYC + 2000) begin
      @(posedge CLK);
      n++;
    end
    check(n > RESTART_CYC - 12 && n < RESTART_CYC + 12, 1'b1);
    cyc(4);
    check(NO_LINK_INDICATOR, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], ST_STARTUP);
    finish_test();
  end
endmodule : tb
`default_nettype wire
